// file: hw/counter_delay_array.sv
// Purpose: Six counter/delay units with oscillator clocking, APB access
// Assumes: All inputs synchronous to MCLK; RC sources emulated by dividers
// Notes:   Oscillator outputs are one-cycle enables, never real clocks
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module counter_delay_array #(
    parameter int unsigned SLOW_DIV = cdu_pkg::SLOW_TICKS
) (
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        EXT_CLK_PIN,
    input  wire logic        OSC_OSC_POWER_DOWN,
    input  wire logic        CHAIN_IN,
    input  wire logic [5:0]  UNIT_DIN,
    input  wire logic [1:0]  UNIT_XCLK,
    output logic      [5:0]  UNIT_OUT,
    output logic      [5:0]  UNIT_OVF,
    output logic      [4:0]  OSC_TAP,
    output logic             OSC_ON
);
    localparam int unsigned N = cdu_pkg::NUM_UNITS;

    logic [31:0] osc_ctrl_r, osc_ctrl_nxt;
    logic [31:0] unit_cfg_r   [N];
    logic [31:0] unit_cfg_nxt [N];
    logic [31:0] prdata_nxt;
    logic        pready_nxt, pslverr_nxt;
    logic        osc_on_nxt;
    logic [15:0] slow_cnt_r, slow_cnt_nxt;
    logic [7:0]  fast_cnt_r, fast_cnt_nxt;
    logic [2:0]  div1_cnt_r, div1_cnt_nxt;
    logic [5:0]  tap_cnt_r   [4];
    logic [5:0]  tap_cnt_nxt [4];
    logic        ext_q_r;
    logic [5:0]  xq_r;
    logic        fund_tick, stage1_tick;
    logic [2:0]  div1_mask;
    logic [4:0]  tap_w;
    logic [5:0]  xsrc_w, out_w, ovf_w, uses_w;

    // Decoded unit index of an address; N means no unit
    function automatic logic [2:0] unit_index(input logic [11:0] a);
        logic [11:0] off;
        off = a - cdu_pkg::ADDR_UNIT_BASE;
        if (a >= cdu_pkg::ADDR_UNIT_BASE && off[1:0] == 2'h0
            && off[11:2] < 10'(N))
            unit_index = off[4:2];
        else
            unit_index = 3'(N);
    endfunction : unit_index

    // Writable bits of a unit; narrow units keep eight value bits
    function automatic logic [31:0] cfg_mask(input int unsigned k);
        cfg_mask = (k == N - 1) ? cdu_pkg::WIDE_MASK
                                : cdu_pkg::NARROW_MASK;
    endfunction : cfg_mask

    // ****************************************************************
    // APB slave
    // ****************************************************************

    // Zero wait states: answer prepared in setup, ready in access
    always_comb begin
        logic [2:0] idx;
        idx          = unit_index(PADDR);
        osc_ctrl_nxt = osc_ctrl_r;
        unit_cfg_nxt = unit_cfg_r;
        prdata_nxt   = PRDATA;
        pready_nxt   = PSEL && !PENABLE;
        pslverr_nxt  = 1'b0;
        if (PSEL && !PENABLE && !PWRITE) begin
            prdata_nxt = 32'h0000_0000;
            if (PADDR == cdu_pkg::ADDR_OSC_CTRL)
                prdata_nxt = osc_ctrl_r;
            else if (PADDR == cdu_pkg::ADDR_STATUS) begin
                prdata_nxt[cdu_pkg::STAT_OSC_BIT] = OSC_ON;
                prdata_nxt[cdu_pkg::STAT_OUT_LSB +: 6] = UNIT_OUT;
            end else if (idx < 3'(N))
                prdata_nxt = unit_cfg_r[idx];
        end
        if (PSEL && !PENABLE) begin
            pslverr_nxt = PADDR != cdu_pkg::ADDR_OSC_CTRL
                       && PADDR != cdu_pkg::ADDR_STATUS
                       && idx == 3'(N);
        end
        if (PSEL && PENABLE && PREADY && PWRITE) begin
            if (PADDR == cdu_pkg::ADDR_OSC_CTRL)
                osc_ctrl_nxt = PWDATA & cdu_pkg::OSC_CTRL_MASK;
            for (int k = 0; k < N; k++) begin
                if (idx == 3'(k))
                    unit_cfg_nxt[k] = PWDATA & cfg_mask(k);
            end
        end
    end

    // Register file and bus outputs
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            osc_ctrl_r <= cdu_pkg::OSC_CTRL_RST;
            for (int k = 0; k < N; k++)
                unit_cfg_r[k] <= cdu_pkg::UNIT_CFG_RST;
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            osc_ctrl_r <= osc_ctrl_nxt;
            unit_cfg_r <= unit_cfg_nxt;
            PRDATA     <= prdata_nxt;
            PREADY     <= pready_nxt;
            PSLVERR    <= pslverr_nxt;
        end
    end

    // ****************************************************************
    // Oscillator and dividers
    // ****************************************************************

    // Power-down wins; mode 1 runs only on demand or when forced
    assign osc_on_nxt = !OSC_OSC_POWER_DOWN
        && (!osc_ctrl_r[cdu_pkg::OSC_MODE_BIT]
            || osc_ctrl_r[cdu_pkg::OSC_FORCE_BIT]
            || (|uses_w));

    // Source select; both dividers run while the osc is on and hold at zero while it is off
    always_comb begin
        slow_cnt_nxt = 16'h0000;
        fast_cnt_nxt = 8'h00;
        fund_tick    = 1'b0;
        if (OSC_ON) begin
            if (slow_cnt_r == 16'(SLOW_DIV - 1))
                slow_cnt_nxt = 16'h0000;
            else
                slow_cnt_nxt = slow_cnt_r + 16'h0001;
            if (fast_cnt_r == 8'(cdu_pkg::FAST_TICKS - 1))
                fast_cnt_nxt = 8'h00;
            else
                fast_cnt_nxt = fast_cnt_r + 8'h01;
            case (osc_ctrl_r[cdu_pkg::OSC_SRC_LSB +: 2])
                cdu_pkg::SRC_SLOW:
                    fund_tick = slow_cnt_r == 16'(SLOW_DIV - 1);
                cdu_pkg::SRC_FAST:
                    fund_tick = fast_cnt_r ==
                                8'(cdu_pkg::FAST_TICKS - 1);
                cdu_pkg::SRC_EXT:
                    fund_tick = EXT_CLK_PIN && !ext_q_r;
                default:
                    fund_tick = 1'b0;
            endcase
        end
    end

    // First stage: divide by 1, 2, 4 or 8
    always_comb begin
        case (osc_ctrl_r[cdu_pkg::OSC_DIV_LSB +: 2])
            2'h0:    div1_mask = 3'h0;
            2'h1:    div1_mask = 3'h1;
            2'h2:    div1_mask = 3'h3;
            default: div1_mask = 3'h7;
        endcase
        stage1_tick  = fund_tick
                    && ((div1_cnt_r & div1_mask) == div1_mask);
        div1_cnt_nxt = !OSC_ON ? 3'h0
                     : fund_tick ? div1_cnt_r + 3'h1 : div1_cnt_r;
    end

    // Second stage: four wrap counters plus the undivided tap
    assign tap_w[0] = stage1_tick;
    generate
        for (genvar t = 0; t < 4; t++) begin : g_tap
            localparam logic [5:0] LAST = 6'(cdu_pkg::TAP_DIV[t] - 1);
            assign tap_w[t+1] = stage1_tick
                             && tap_cnt_r[t] == LAST;
            always_comb begin
                if (!OSC_ON)
                    tap_cnt_nxt[t] = 6'h00;
                else if (!stage1_tick)
                    tap_cnt_nxt[t] = tap_cnt_r[t];
                else if (tap_cnt_r[t] == LAST)
                    tap_cnt_nxt[t] = 6'h00;
                else
                    tap_cnt_nxt[t] = tap_cnt_r[t] + 6'h01;
            end
        end
    endgenerate

    // Oscillator state registers
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            slow_cnt_r <= 16'h0000;
            fast_cnt_r <= 8'h00;
            div1_cnt_r <= 3'h0;
            tap_cnt_r  <= '{default: 6'h00};
            ext_q_r    <= 1'b0;
            xq_r       <= 6'h00;
            OSC_ON     <= 1'b0;
            OSC_TAP    <= 5'h00;
        end else begin
            slow_cnt_r <= slow_cnt_nxt;
            fast_cnt_r <= fast_cnt_nxt;
            div1_cnt_r <= div1_cnt_nxt;
            tap_cnt_r  <= tap_cnt_nxt;
            ext_q_r    <= EXT_CLK_PIN;
            xq_r       <= xsrc_w;
            OSC_ON     <= osc_on_nxt;
            OSC_TAP    <= tap_w;
        end
    end

    // ****************************************************************
    // Units
    // ****************************************************************

    // Unit clock select; reserved code gives no clock
    function automatic logic pick_tick(input logic [2:0] sel,
                                       input logic [4:0] taps,
                                       input logic ext_ok,
                                       input logic ext_edge,
                                       input logic chain);
        case (sel)
            cdu_pkg::CLK_OSC:   pick_tick = taps[0];
            cdu_pkg::CLK_DIV4:  pick_tick = taps[1];
            cdu_pkg::CLK_DIV12: pick_tick = taps[2];
            cdu_pkg::CLK_DIV24: pick_tick = taps[3];
            cdu_pkg::CLK_DIV64: pick_tick = taps[4];
            cdu_pkg::CLK_EXT:   pick_tick = ext_ok && ext_edge;
            cdu_pkg::CLK_CHAIN: pick_tick = chain;
            default:            pick_tick = 1'b0;
        endcase
    endfunction : pick_tick

    generate
        for (genvar k = 0; k < N; k++) begin : g_unit
            logic       mode_w;
            logic [2:0] sel_w;
            cdu_if u_if ();

            assign mode_w = unit_cfg_r[k][cdu_pkg::UNIT_MODE_BIT];
            assign sel_w  = unit_cfg_r[k][cdu_pkg::UNIT_SEL_LSB +: 3];
            // First two units have a clock pin of their own
            assign xsrc_w[k] = (k < 2) ? UNIT_XCLK[k % 2]
                                       : UNIT_DIN[k];
            // Delay on an internal source or any counter needs the osc
            assign uses_w[k] = mode_w || sel_w <= cdu_pkg::CLK_DIV64;
            assign u_if.mode     = mode_w;
            assign u_if.edge_sel =
                unit_cfg_r[k][cdu_pkg::UNIT_EDGE_LSB +: 2];
            assign u_if.value    =
                unit_cfg_r[k][cdu_pkg::UNIT_VAL_LSB +: 14];
            assign u_if.tick = pick_tick(sel_w, tap_w,
                (k < 2) || mode_w,
                xsrc_w[k] && !xq_r[k],
                (k == 0) ? CHAIN_IN : ovf_w[(k + N - 1) % N]);
            assign u_if.din    = UNIT_DIN[k];
            assign u_if.rst_in = UNIT_DIN[k];
            assign u_if.rst_en = (k < 2);
            assign out_w[k] = u_if.dout;
            assign ovf_w[k] = u_if.ovf;

            counter_delay_unit #(
                .W (k == N - 1 ? cdu_pkg::WIDE_W
                               : cdu_pkg::NARROW_W)
            ) u_unit (
                .clk   (MCLK),
                .rst_n (RESETN),
                .port  (u_if.unit)
            );
        end
    endgenerate

    // Unit results are already registered inside each unit
    assign UNIT_OUT = out_w;
    assign UNIT_OVF = ovf_w;

endmodule : counter_delay_array

// file: include/cdu_pkg.sv
// Purpose: Shared constants for the counter/delay array and its clocking
// Assumes: 125 MHz system clock, APB register access
// Notes:   All offsets are byte addresses of aligned 32-bit words
package cdu_pkg;

    // ****************************************************************
    // Clocking
    // ****************************************************************
    localparam int unsigned MCLK_HZ     = 125_000_000;
    localparam int unsigned RC_SLOW_HZ  = 25_000;
    localparam int unsigned RC_FAST_HZ  = 2_000_000;
    // Shortest period rounds down to whole cycles
    localparam int unsigned SLOW_TICKS  = MCLK_HZ / RC_SLOW_HZ;
    localparam int unsigned FAST_TICKS  = MCLK_HZ / RC_FAST_HZ;
    localparam int unsigned TAP_DIV [4] = '{4, 12, 24, 64};

    // ****************************************************************
    // Array shape
    // ****************************************************************
    localparam int unsigned NUM_UNITS = 6;
    localparam int unsigned NARROW_W  = 8;
    localparam int unsigned WIDE_W    = 14;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [11:0] ADDR_OSC_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_UNIT_BASE = 12'h010;
    localparam int unsigned OSC_MODE_BIT   = 0;
    localparam int unsigned OSC_FORCE_BIT  = 1;
    localparam int unsigned OSC_SRC_LSB    = 2;
    localparam int unsigned OSC_DIV_LSB    = 4;
    localparam int unsigned UNIT_MODE_BIT  = 0;
    localparam int unsigned UNIT_SEL_LSB   = 1;
    localparam int unsigned UNIT_EDGE_LSB  = 4;
    localparam int unsigned UNIT_VAL_LSB   = 16;
    localparam int unsigned STAT_OSC_BIT   = 0;
    localparam int unsigned STAT_OUT_LSB   = 8;
    localparam logic [31:0] OSC_CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] UNIT_CFG_RST   = 32'h0000_0000;
    localparam logic [31:0] OSC_CTRL_MASK  = 32'h0000_003f;
    localparam logic [31:0] NARROW_MASK    = 32'h00ff_003f;
    localparam logic [31:0] WIDE_MASK      = 32'h3fff_003f;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    localparam logic [2:0] CLK_OSC   = 3'h0;
    localparam logic [2:0] CLK_DIV4  = 3'h1;
    localparam logic [2:0] CLK_DIV12 = 3'h2;
    localparam logic [2:0] CLK_DIV24 = 3'h3;
    localparam logic [2:0] CLK_DIV64 = 3'h4;
    localparam logic [2:0] CLK_EXT   = 3'h5;
    localparam logic [2:0] CLK_CHAIN = 3'h7;
    localparam logic [1:0] EDGE_BOTH = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] SRC_SLOW  = 2'h0;
    localparam logic [1:0] SRC_FAST  = 2'h1;
    localparam logic [1:0] SRC_EXT   = 2'h2;

endpackage : cdu_pkg

// file: include/cdu_if.sv
// Purpose: Carrier between the array controller and one unit
// Assumes: All signals synchronous to the system clock
// Notes:   value is wide enough for the widest unit
`timescale 1ns/1ps
interface cdu_if;
    logic        mode;
    logic [1:0]  edge_sel;
    logic [13:0] value;
    logic        tick;
    logic        din;
    logic        rst_in;
    logic        rst_en;
    logic        dout;
    logic        ovf;
    modport unit (input mode, edge_sel, value, tick, din, rst_in, rst_en,
                  output dout, ovf);
    modport ctrl (output mode, edge_sel, value, tick, din, rst_in, rst_en,
                  input dout, ovf);
endinterface : cdu_if

// file: hw/counter_delay_unit.sv
// Purpose: One counter/delay generator
// Assumes: tick is a one-cycle enable of the selected clock
// Notes:   Width W is 8 or 14
`timescale 1ns/1ps
module counter_delay_unit #(
    parameter int unsigned W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    cdu_if.unit      port
);
    typedef enum {ST_IDLE, ST_WAIT} dly_state_e;

    dly_state_e   state_r, state_nxt;
    logic [W:0]   cnt_r, cnt_nxt;
    logic         dout_r, dout_nxt;
    logic         ovf_r, ovf_nxt;
    logic         rst_q_r;
    logic [W:0]   load_w;
    logic         rise_w, fall_w, rst_hit_w;

    // Edge field decides which input transitions wait
    function automatic logic edge_delayed(input logic [1:0] e,
                                          input logic rising);
        case (e)
            cdu_pkg::EDGE_BOTH: edge_delayed = 1'b1;
            cdu_pkg::EDGE_FALL: edge_delayed = !rising;
            cdu_pkg::EDGE_RISE: edge_delayed = rising;
            default:            edge_delayed = 1'b0;
        endcase
    endfunction : edge_delayed

    assign load_w = {1'b0, port.value[W-1:0]};
    assign rise_w = port.rst_in & ~rst_q_r;
    assign fall_w = ~port.rst_in & rst_q_r;

    // Counter reset select; edge code 11 means level reset
    always_comb begin
        case (port.edge_sel)
            cdu_pkg::EDGE_BOTH: rst_hit_w = rise_w | fall_w;
            cdu_pkg::EDGE_FALL: rst_hit_w = fall_w;
            cdu_pkg::EDGE_RISE: rst_hit_w = rise_w;
            default:            rst_hit_w = port.rst_in;
        endcase
    end

    // Next state for both modes
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        dout_nxt  = dout_r;
        ovf_nxt   = 1'b0;
        if (port.mode) begin
            state_nxt = ST_IDLE;
            dout_nxt  = 1'b0;
            if (port.rst_en && rst_hit_w) begin
                cnt_nxt = load_w;
            end else if (port.tick) begin
                if (cnt_r == '0) begin
                    cnt_nxt  = load_w;
                    ovf_nxt  = 1'b1;
                    dout_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - (W+1)'(1);
                end
            end
        end else if (port.din == dout_r) begin
            // Input came back before expiry: pulse is swallowed
            state_nxt = ST_IDLE;
        end else if (state_r == ST_IDLE) begin
            if (edge_delayed(port.edge_sel, port.din)) begin
                state_nxt = ST_WAIT;
                cnt_nxt   = load_w + (W+1)'(1);
            end else begin
                dout_nxt = port.din;
            end
        end else if (port.tick) begin
            // Value plus two ticks; first tick phase is the fraction
            if (cnt_r == '0) begin
                dout_nxt  = port.din;
                ovf_nxt   = 1'b1;
                state_nxt = ST_IDLE;
            end else begin
                cnt_nxt = cnt_r - (W+1)'(1);
            end
        end
    end

    // Count clears at reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
            dout_r  <= 1'b0;
            ovf_r   <= 1'b0;
            rst_q_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            dout_r  <= dout_nxt;
            ovf_r   <= ovf_nxt;
            rst_q_r <= port.rst_in;
        end
    end

    assign port.dout = dout_r;
    assign port.ovf  = ovf_r;

endmodule : counter_delay_unit

// file: verif/cdu_assertions.sv
// Purpose: Port checks of the counter/delay array
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound below to every array instance
`timescale 1ns/1ps
module cdu_checker (
    input wire logic        MCLK,
    input wire logic        RESETN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        OSC_OSC_POWER_DOWN,
    input wire logic [5:0]  UNIT_OUT,
    input wire logic [5:0]  UNIT_OVF,
    input wire logic [4:0]  OSC_TAP,
    input wire logic        OSC_ON
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    // Zero wait states, no answer outside a transfer
    zero_wait_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready in access");
    ready_idle_a: assert property (!PSEL |=> !PREADY)
        else $error("ready unselected");
    err_access_a: assert property (PSLVERR |-> PREADY && PENABLE)
        else $error("error outside access");
    err_zero_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
        else $error("refused read not zero");
    // Power down outranks every enable
    osc_power_down_a: assert property (OSC_OSC_POWER_DOWN [*2] |-> !OSC_ON)
        else $error("osc on in power down");
    tap_stop_a: assert property (
        !OSC_ON && !$past(OSC_ON) |-> OSC_TAP == 5'h0)
        else $error("taps while stopped");
    ovf_pulse_a: assert property ((UNIT_OVF & $past(UNIT_OVF)) == 6'h0)
        else $error("overflow longer than a cycle");
    reset_clear_a: assert property (
        $rose(RESETN) |-> (UNIT_OUT | UNIT_OVF) == 6'h0 && !OSC_ON)
        else $error("outputs set after reset");
endmodule : cdu_checker
bind counter_delay_array cdu_checker cdu_checker_inst (
    .MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .OSC_OSC_POWER_DOWN(OSC_OSC_POWER_DOWN), .UNIT_OUT(UNIT_OUT),
    .UNIT_OVF(UNIT_OVF), .OSC_TAP(OSC_TAP), .OSC_ON(OSC_ON));

// file: verif/matrix_model.sv
// Purpose: Routing matrix stand-in feeding the array
// Assumes: Runs on the system clock
// Notes:   Clocks park low while run is low
`timescale 1ns/1ps
module matrix_model (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [5:0] din_req,
    output logic      [5:0] din,
    output logic      [1:0] xclk,
    output logic            chain,
    output logic            pin_clk
);
    logic [2:0] phase_r = 3'h0;
    logic [5:0] din_r   = 6'h0;
    // One free count sets every rate, so spacing is exact
    always @(posedge clk) begin
        phase_r <= run ? phase_r + 3'h1 : 3'h0;
        din_r   <= din_req;
    end
    assign pin_clk = run & phase_r[1];        // Period 4 cycles
    assign xclk    = {2{pin_clk}};
    assign chain   = run & (phase_r == 3'h7);
    assign din     = din_r;
endmodule : matrix_model

// file: verif/testbench.sv
// Purpose: Self-checking bench for the counter/delay array
// Assumes: Oscillator taken from the model's pin clock, except in the register tests and the slow and fast source checks
// Notes:   Pin period of 4 cycles makes every tick spacing exact
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end \
end
module testbench;
    typedef struct {int u; logic [2:0] c; logic [13:0] v; int per;} row_s;
    logic        mclk = 1'b0;
    logic        resetn, psel, penable, pwrite, osc_power_down, run, er;
    logic        pready, pslverr, chain, pin_clk, osc_on;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  din_req, din, unit_out, unit_ovf;
    logic [1:0]  xclk;
    logic [4:0]  osc_tap;
    int          num_errors = 0, n_compared = 0, n;
    // Unit, clock code, value, tick period in cycles
    row_s rows [8] = '{'{0, 3'h0, 14'd3, 4}, '{5, 3'h1, 14'd1, 16},
        '{2, 3'h2, 14'd0, 48}, '{3, 3'h3, 14'd0, 96},
        '{4, 3'h4, 14'd0, 256}, '{1, 3'h5, 14'd2, 4},
        '{0, 3'h7, 14'd1, 8}, '{5, 3'h0, 14'd300, 4}};
    counter_delay_array #(.SLOW_DIV(8)) counter_delay_array_inst (
        .MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_CLK_PIN(pin_clk),
        .OSC_OSC_POWER_DOWN(osc_power_down), .CHAIN_IN(chain), .UNIT_DIN(din),
        .UNIT_XCLK(xclk), .UNIT_OUT(unit_out), .UNIT_OVF(unit_ovf),
        .OSC_TAP(osc_tap), .OSC_ON(osc_on));
    matrix_model matrix_model_inst (.clk(mclk), .run(run),
        .din_req(din_req), .din(din), .xclk(xclk), .chain(chain),
        .pin_clk(pin_clk));
    initial begin
        forever #4 mclk = ~mclk;
    end
    task automatic finish_test();
        $display("compared %0d, wrong %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    // A used-up bound ends the run
    task automatic guard(input bit hit);
        if (hit) begin
            num_errors++;
            finish_test();
        end
    endtask : guard
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k = 0;
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        guard(k == 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic ucfg(input int u, input logic [2:0] c,
                        input logic [13:0] v, input logic [1:0] e,
                        input logic m);
        apb(1'b1, 12'(cdu_pkg::ADDR_UNIT_BASE + 4 * u),
            {2'h0, v, 10'h0, e, c, m});
    endtask : ucfg
    // Source 0 overflow, 1 output, 2 oscillator level, 3 taps
    task automatic wait_for(input int s, input int k, input logic lvl);
        logic [5:0] v;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            v = (s == 0) ? unit_ovf : (s == 1) ? unit_out
              : (s == 2) ? {6{osc_on}} : {1'b0, osc_tap};
        end while (v[k] !== lvl && n < 3000);
        guard(n == 3000);
    endtask : wait_for
    // Counts cycles with the output not low
    task automatic quiet(input int k, input int c);
        n = 0;
        repeat (c) begin
            @(posedge mclk);
            n += int'(unit_out[k] !== 1'b0);
        end
    endtask : quiet
    initial begin
        {resetn, psel, penable, pwrite, osc_power_down, run} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        din_req = 6'h0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        apb(1'b0, cdu_pkg::ADDR_UNIT_BASE, 32'h0);
        `CHK("unit reset", cdu_pkg::UNIT_CFG_RST, rd)
        wait_for(2, 0, 1'b1);
        `CHK("auto on", 1'b1, osc_on)
        apb(1'b1, 12'h024, 32'hffff_ffff);
        apb(1'b0, 12'h024, 32'h0);
        `CHK("wide field", cdu_pkg::WIDE_MASK, rd)
        apb(1'b1, 12'h018, 32'hffff_ffff);
        apb(1'b0, 12'h018, 32'h0);
        `CHK("narrow field", cdu_pkg::NARROW_MASK, rd)
        apb(1'b0, 12'h008, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {er, rd})
        apb(1'b1, cdu_pkg::ADDR_OSC_CTRL, 32'h8);
        apb(1'b0, cdu_pkg::ADDR_OSC_CTRL, 32'h0);
        `CHK("osc ctrl", 32'h8, rd)
        $display("register test done");
        run <= 1'b1;
        foreach (rows[i]) begin
            ucfg(rows[i].u, rows[i].c, rows[i].v, 2'h0, 1'b1);
            wait_for(0, rows[i].u, 1'b1);
            wait_for(0, rows[i].u, 1'b1);
            `CHK("period", (rows[i].v + 1) * rows[i].per, n)
            `CHK("out pulse", 1'b1, unit_out[rows[i].u])
            $display("counter row %0d done", i);
        end
        // Level reset pins the counter; input rises before the new code
        din_req[0] <= 1'b1;
        ucfg(0, 3'h0, 14'd3, 2'h3, 1'b1);
        quiet(0, 40);
        `CHK("level reset", 0, n)
        din_req[0] <= 1'b0;
        // Undelayed code first, so a left-over counter pulse clears
        ucfg(1, 3'h0, 14'd2, 2'h3, 1'b0);
        // Delayed edges land in the value plus two tick window
        for (int e = 0; e < 4; e++) begin
            ucfg(1, 3'h0, 14'd2, 2'(e), 1'b0);
            din_req[1] <= 1'b1;
            wait_for(1, 1, 1'b1);
            `CHK("rise", 1'b1, e[0] ? n < 5 : n inside {[14:24]})
            din_req[1] <= 1'b0;
            wait_for(1, 1, 1'b0);
            `CHK("fall", 1'b1, e[1] ? n < 5 : n inside {[14:24]})
        end
        ucfg(1, 3'h0, 14'd2, 2'h0, 1'b0);
        din_req[1] <= 1'b1;
        repeat (5) @(posedge mclk);
        din_req[1] <= 1'b0;
        quiet(1, 40);
        `CHK("short pulse", 0, n)
        for (int u = 0; u < 6; u++) begin
            ucfg(u, 3'h5, 14'd0, 2'h3, 1'b0);
        end
        ucfg(2, 3'h5, 14'd0, 2'h0, 1'b0);
        din_req[2] <= 1'b1;
        quiet(2, 60);
        `CHK("no ext clock", 0, n)
        $display("delay test done");
        // Third pulse spacing; the first may still be on the old setting
        apb(1'b1, cdu_pkg::ADDR_OSC_CTRL, 32'h18);
        repeat (3) wait_for(3, 1, 1'b1);
        `CHK("first div", 32, n)
        apb(1'b1, cdu_pkg::ADDR_OSC_CTRL, 32'h0);
        repeat (3) wait_for(3, 0, 1'b1);
        `CHK("slow src", 8, n)
        apb(1'b1, cdu_pkg::ADDR_OSC_CTRL, 32'h4);
        repeat (3) wait_for(3, 0, 1'b1);
        `CHK("fast src", cdu_pkg::FAST_TICKS, n)
        $display("clock test done");
        apb(1'b1, cdu_pkg::ADDR_OSC_CTRL, 32'h9);
        wait_for(2, 0, 1'b0);
        `CHK("idle off", 1'b0, osc_on)
        apb(1'b1, cdu_pkg::ADDR_OSC_CTRL, 32'hb);
        wait_for(2, 0, 1'b1);
        `CHK("forced on", 1'b1, osc_on)
        apb(1'b1, cdu_pkg::ADDR_OSC_CTRL, 32'h9);
        wait_for(2, 0, 1'b0);
        ucfg(4, 3'h0, 14'd0, 2'h0, 1'b1);
        wait_for(2, 0, 1'b1);
        `CHK("counter on", 1'b1, osc_on)
        osc_power_down <= 1'b1;
        wait_for(2, 0, 1'b0);
        `CHK("power down", 1'b0, osc_on)
        resetn <= 1'b0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        apb(1'b0, 12'h018, 32'h0);
        `CHK("cfg after reset", 32'h0, rd)
        $display("power test done");
        finish_test();
    end
endmodule : testbench
